// ==== ebsme_cfg.svh ====
// timing and reset constants for the external bus strobe and mode entry block
// assumes the including file runs on the crystal clock, one edge per crystal period
`ifndef EBSME_CFG_SVH
`define EBSME_CFG_SVH
`define EBSME_MC_STD 4'hc
`define EBSME_MC_DBL 4'h6
`define EBSME_HALF_STD 4'h6
`define EBSME_HALF_DBL 4'h3
`define EBSME_RST_MC 9'h002
`define EBSME_HOST_MC 9'h014
`define EBSME_CNT_MAX 9'h1ff
`define EBSME_AUX_RST 4'hf
`define EBSME_P2_RST 8'hff
`endif

// ==== ebsme_pkg.sv ====
// shared types for the external bus strobe and mode entry block
// assumes the core hands data accesses over as one packed request
package ebsme_pkg;
	// operating mode after reset, one-hot
	typedef enum logic [2:0] {
		EBSME_IN_RESET = 3'h1,
		EBSME_NORMAL = 3'h2,
		EBSME_HOST = 3'h4
	} ebsme_mode_t;
	// one external data memory access from the core
	typedef struct packed {
		logic valid;
		logic write;
		logic wide;
		logic [15:0] addr;
	} ebsme_req_t;
	// a two-way pin seen from the design
	typedef struct packed {
		logic o;
		logic oe;
	} ebsme_pin_t;
endpackage

// ==== ebsme_top.sv ====
// external bus strobes, reset filter and host mode entry of the controller
// assumes clk is the crystal clock; pins arrive unsynchronised, core inputs are on clk
`include "ebsme_cfg.svh"
module ebsme_top (
	input wire logic clk,
	input wire logic reset,
	input wire logic reset_pin,
	input wire logic external_fetch_select_n,
	input wire logic lock_level4,
	input wire logic double_speed,
	input wire logic latch_pulse_off,
	input wire logic [15:0] fetch_addr,
	input wire ebsme_pkg::ebsme_req_t data_req,
	input wire logic [7:0] p2_latch,
	input wire logic aux_wr,
	input wire logic [3:0] aux_wdata,
	input wire logic program_fetch_strobe_n_i,
	input wire logic latch_pin_i,
	input wire logic [3:0] aux_nibble_port_i,
	output ebsme_pkg::ebsme_pin_t program_fetch_strobe_n,
	output ebsme_pkg::ebsme_pin_t latch_pin,
	output logic [7:0] p2_o,
	output logic [7:0] p2_oe,
	output logic [7:0] addr_lo,
	output logic rd_n,
	output logic wr_n,
	output logic data_ack,
	output logic [3:0] aux_nibble_port_o,
	output logic [3:0] aux_nibble_port_oe,
	output logic [3:0] aux_rdata,
	output logic program_pulse_n,
	output ebsme_pkg::ebsme_mode_t mode,
	output logic ext_exec,
	output logic cpu_reset
);
	import ebsme_pkg::*;

	logic [1:0] rst_s_r, program_fetch_strobe_n_s_r, ea_s_r, ale_s_r; // two-stage synchronisers
	logic program_fetch_strobe_n_d_r; // previous synchronised fetch strobe, for edge detect
	logic [3:0] aux_s1_r; // first stage of nibble port sync
	logic [3:0] ph_r; // crystal clock position inside the machine cycle
	logic [8:0] rst_cnt_r; // machine cycles reset has been high, saturating
	logic [3:0] mc_sub_r; // crystal clocks inside the current reset count step
	logic host_req_r; // fetch strobe fell while reset held
	logic data_cyc_r; // this machine cycle carries a data access
	ebsme_req_t cur_r, dreq; // access latched at cycle start; access shown in the first half
	ebsme_mode_t mode_r; // operating mode
	logic [3:0] mc_len, half_len, pos; // cycle length, half length, position in half
	logic half1, take, dfirst; // second half; request taken now; first half of a data cycle
	logic fetch_win; // inside the strobe window of a half
	logic ext_now; // external execution allowed this clock

	// machine cycle length follows the speed option
	always_comb begin
		mc_len = double_speed ? `EBSME_MC_DBL : `EBSME_MC_STD;
		half_len = double_speed ? `EBSME_HALF_DBL : `EBSME_HALF_STD;
		half1 = (ph_r >= half_len);
		pos = half1 ? ph_r - half_len : ph_r;
		fetch_win = (pos != 4'h0) && (pos != half_len - 4'h1);
		// lock level four overrides the select pin
		ext_now = (mode_r == EBSME_NORMAL) && !ea_s_r[1] && !lock_level4;
		// the data address must already stand when the first latch pulse closes
		take = (ph_r == 4'h0) && data_req.valid && (mode_r == EBSME_NORMAL) && !data_ack;
		dfirst = take || (data_cyc_r && !half1);
		dreq = take ? data_req : cur_r;
	end
	// pin synchronisers; only the second stage is read by logic
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rst_s_r <= 2'h0;
			program_fetch_strobe_n_s_r <= 2'h3;
			ea_s_r <= 2'h3;
			ale_s_r <= 2'h3;
			aux_s1_r <= 4'hf;
			aux_rdata <= 4'hf;
			program_fetch_strobe_n_d_r <= 1'b1;
		end else begin
			rst_s_r <= {rst_s_r[0], reset_pin};
			program_fetch_strobe_n_s_r <= {program_fetch_strobe_n_s_r[0], program_fetch_strobe_n_i};
			ea_s_r <= {ea_s_r[0], external_fetch_select_n};
			ale_s_r <= {ale_s_r[0], latch_pin_i};
			aux_s1_r <= aux_nibble_port_i;
			aux_rdata <= aux_s1_r;
			program_fetch_strobe_n_d_r <= program_fetch_strobe_n_s_r[1];
		end
	end
	// machine cycle phase counter, free running
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			ph_r <= 4'h0;
		else if (ph_r >= mc_len - 4'h1)
			ph_r <= 4'h0;
		else
			ph_r <= ph_r + 4'h1;
	end
	// count machine cycles of reset high; a low level restarts the count
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rst_cnt_r <= 9'h000;
			mc_sub_r <= 4'h0;
		end else if (!rst_s_r[1]) begin
			rst_cnt_r <= 9'h000;
			mc_sub_r <= 4'h0;
		end else if (mc_sub_r >= mc_len - 4'h1) begin
			mc_sub_r <= 4'h0;
			if (rst_cnt_r != `EBSME_CNT_MAX)
				rst_cnt_r <= rst_cnt_r + 9'h001;
		end else begin
			mc_sub_r <= mc_sub_r + 4'h1;
		end
	end
	// mode selection; a falling fetch strobe during a long enough reset selects host
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mode_r <= EBSME_IN_RESET;
			host_req_r <= 1'b0;
		end else begin
			case (mode_r)
				EBSME_IN_RESET: begin
					// edge must come while reset has been high over 20 cycles
					if (rst_s_r[1] && program_fetch_strobe_n_d_r && !program_fetch_strobe_n_s_r[1] &&
					    rst_cnt_r > `EBSME_HOST_MC)
						host_req_r <= 1'b1;
					if (!rst_s_r[1])
						mode_r <= host_req_r ? EBSME_HOST : EBSME_NORMAL;
				end
				EBSME_NORMAL, EBSME_HOST: begin
					host_req_r <= 1'b0;
					if (rst_cnt_r >= `EBSME_RST_MC)
						mode_r <= EBSME_IN_RESET;
				end
				default: mode_r <= EBSME_IN_RESET;
			endcase
		end
	end
	// data access is taken at cycle start and acknowledged at cycle end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			data_cyc_r <= 1'b0;
			cur_r <= '0;
			data_ack <= 1'b0;
		end else begin
			data_ack <= 1'b0;
			if (ph_r == 4'h0) begin
				data_cyc_r <= take;
				cur_r <= data_req;
			end
			if (ph_r == mc_len - 4'h1 && data_cyc_r) begin
				data_ack <= 1'b1;
				data_cyc_r <= 1'b0;
			end
		end
	end
	// latch pulse at the start of each half; second one dropped in a data cycle
	// the pin is released outside normal mode and read as the programming pulse input only in host mode
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			latch_pin <= '0;
			program_pulse_n <= 1'b1;
			addr_lo <= 8'h00;
		end else begin
			latch_pin.oe <= (mode_r == EBSME_NORMAL);
			program_pulse_n <= (mode_r == EBSME_HOST) ? ale_s_r[1] : 1'b1;
			// half rate gives 1/6 of crystal in 12 clock mode, 1/3 in 6
			latch_pin.o <= (mode_r == EBSME_NORMAL) && !latch_pulse_off &&
			               (pos == 4'h0) && !(half1 && data_cyc_r);
			if (pos == 4'h0)
				addr_lo <= dfirst ? dreq.addr[7:0] : fetch_addr[7:0];
		end
	end
	// fetch strobe: high for internal code, two pulses for external
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			program_fetch_strobe_n <= '{o: 1'b1, oe: 1'b0};
			ext_exec <= 1'b0;
		end else begin
			// released during reset so the host can pull it low
			program_fetch_strobe_n.oe <= (mode_r == EBSME_NORMAL);
			ext_exec <= ext_now;
			// the first half pulse is given over to the data strobe
			program_fetch_strobe_n.o <= !(ext_now && fetch_win &&
			                             !(!half1 && data_cyc_r));
		end
	end
	// data read and write strobes in the first half of a data cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rd_n <= 1'b1;
			wr_n <= 1'b1;
		end else begin
			rd_n <= !(data_cyc_r && !half1 && fetch_win && !cur_r.write);
			wr_n <= !(data_cyc_r && !half1 && fetch_win && cur_r.write);
		end
	end
	// second port carries the high address, driven hard both ways
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			p2_o <= `EBSME_P2_RST;
			p2_oe <= 8'h00;
		end else if (dfirst && dreq.wide) begin
			p2_o <= dreq.addr[15:8];
			p2_oe <= 8'hff;
		end else if (ext_now && !dfirst) begin
			p2_o <= fetch_addr[15:8];
			p2_oe <= 8'hff;
		end else begin
			// quasi bidirectional: pull-up carries ones, only zeros are driven
			p2_o <= 8'h00;
			p2_oe <= ~p2_latch;
		end
	end

	// nibble port latch; a one leaves the bit on its pull-up as input
	logic [3:0] aux_latch_r; // written port value
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			aux_latch_r <= `EBSME_AUX_RST;
		else if (aux_wr)
			aux_latch_r <= aux_wdata;
	end
	generate
		for (genvar i = 0; i < 4; i++) begin : g_aux
			// per bit: drive low for a zero, release for a one
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					aux_nibble_port_o[i] <= 1'b0;
					aux_nibble_port_oe[i] <= 1'b0;
				end else begin
					aux_nibble_port_o[i] <= 1'b0;
					aux_nibble_port_oe[i] <= !aux_latch_r[i];
				end
			end
		end
	endgenerate

	// reset to the core and visible mode
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cpu_reset <= 1'b1;
			mode <= EBSME_IN_RESET;
		end else begin
			cpu_reset <= (mode_r == EBSME_IN_RESET);
			mode <= mode_r;
		end
	end

	// checks
	a_int_program_fetch_strobe_n_high: assert property (@(posedge clk) disable iff (reset)
		!ext_now |=> program_fetch_strobe_n.o) else $error("fetch strobe low on internal code");
	a_lock_internal: assert property (@(posedge clk) disable iff (reset)
		lock_level4 |=> !ext_exec) else $error("external exec under lock");
	a_ea_select: assert property (@(posedge clk) disable iff (reset)
		(mode_r == EBSME_NORMAL && !ea_s_r[1] && !lock_level4) |=> ext_exec)
		else $error("select pin low but no external exec");
	a_latch_off: assert property (@(posedge clk) disable iff (reset)
		latch_pulse_off |=> !latch_pin.o) else $error("latch pulse while off");
	a_latch_width: assert property (@(posedge clk) disable iff (reset)
		$rose(latch_pin.o) |=> !latch_pin.o [*2]) else $error("latch pulse too long or fast");
	a_strobe_excl: assert property (@(posedge clk) disable iff (reset)
		!(!rd_n && !wr_n) && !(!rd_n && !program_fetch_strobe_n.o))
		else $error("strobes overlap");
	a_rst_two_mc: assert property (@(posedge clk) disable iff (reset)
		(mode_r == EBSME_NORMAL && rst_cnt_r == `EBSME_RST_MC) |=> mode_r == EBSME_IN_RESET)
		else $error("reset not taken after two cycles");
	a_host_entry: assert property (@(posedge clk) disable iff (reset)
		(mode_r == EBSME_IN_RESET && !rst_s_r[1] && host_req_r) |=> mode_r == EBSME_HOST)
		else $error("host request not honoured");
	a_program_pulse_n_input: assert property (@(posedge clk) disable iff (reset)
		mode_r == EBSME_HOST |=> !latch_pin.oe && !program_fetch_strobe_n.oe)
		else $error("pin driven in host mode");
	a_data_skip: assert property (@(posedge clk) disable iff (reset)
		(data_cyc_r && half1 && pos == 4'h0) |=> !latch_pin.o)
		else $error("latch pulse not skipped");
	c_host: cover property (@(posedge clk) disable iff (reset) mode_r == EBSME_HOST);
	c_read: cover property (@(posedge clk) disable iff (reset) $fell(rd_n));
	c_write: cover property (@(posedge clk) disable iff (reset) $fell(wr_n));
	c_ext_fetch: cover property (@(posedge clk) disable iff (reset) $fell(program_fetch_strobe_n.o));
endmodule

// ==== ebsme_mem_model.sv ====
// partner: external memories behind an address latch, plus the host on shared pins
// assumes pull-ups on the strobe and latch pins; the host drives only on request
module ebsme_mem_model (
	input wire logic clk,
	input wire ebsme_pkg::ebsme_pin_t fetch_pin,
	input wire ebsme_pkg::ebsme_pin_t latch_pin,
	input wire logic [7:0] addr_lo,
	input wire logic [7:0] p2_o,
	input wire logic rd_n,
	input wire logic host_fetch_low,
	input wire logic host_latch_drive,
	input wire logic host_latch_level,
	output logic fetch_w,
	output logic latch_w,
	output logic [15:0] rd_addr
);
	import ebsme_pkg::*;
	logic [7:0] lo_q; // low byte held by the latch
	// an undriven pin floats up to its pull-up, never to the last value
	assign fetch_w = fetch_pin.oe ? fetch_pin.o : !host_fetch_low;
	// the host owns the latch pin once the device lets go of it
	assign latch_w = latch_pin.oe ? latch_pin.o : (host_latch_drive ? host_latch_level : 1'b1);
	// latch closes on the falling side of the pulse
	always @(negedge latch_w) lo_q = addr_lo;
	// the start of a read shows the full address to the memory
	always @(negedge rd_n) rd_addr = {p2_o, lo_q};
endmodule

// ==== tb_external_bus_strobes_and_mode_entry.sv ====
// self-checking bench for the bus strobes and mode entry block
// assumes the memory model resolves the shared pins; counts strobe edges per window
module tb_external_bus_strobes_and_mode_entry;
	timeunit 1ns;
	timeprecision 1ps;
	import ebsme_pkg::*;
	logic clk = 0, reset = 1, reset_pin = 0, efs_n = 1, lock4 = 0, dbl = 0, lpo = 0;
	logic aux_wr = 0, host_fetch_low = 0, host_latch_drive = 0, host_latch_level = 1;
	logic [3:0] aux_wdata = 4'h0, ax_o, ax_oe, aux_rdata;
	ebsme_req_t data_req = '0;
	ebsme_pin_t fsn, lpin;
	ebsme_mode_t mode;
	logic [7:0] p2_o, p2_oe, addr_lo;
	logic rd_n, wr_n, data_ack, program_pulse_n, ext_exec, cpu_reset, fetch_w, latch_w;
	logic la_q, fs_q, rd_q, wr_q;
	logic [15:0] rd_addr;
	int n_mismatch = 0, check_count = 0, cyc = 0, n_ale = 0, n_fs = 0, n_rd = 0, n_wr = 0;
	ebsme_top ebsme_top_inst (.clk(clk), .reset(reset), .reset_pin(reset_pin),
		.external_fetch_select_n(efs_n), .lock_level4(lock4), .double_speed(dbl),
		.latch_pulse_off(lpo), .fetch_addr(16'h0400), .data_req(data_req), .p2_latch(8'hff),
		.aux_wr(aux_wr), .aux_wdata(aux_wdata), .program_fetch_strobe_n_i(fetch_w),
		.latch_pin_i(latch_w), .aux_nibble_port_i(~ax_oe | ax_o),
		.program_fetch_strobe_n(fsn), .latch_pin(lpin), .p2_o(p2_o), .p2_oe(p2_oe),
		.addr_lo(addr_lo), .rd_n(rd_n), .wr_n(wr_n), .data_ack(data_ack),
		.aux_nibble_port_o(ax_o), .aux_nibble_port_oe(ax_oe), .aux_rdata(aux_rdata),
		.program_pulse_n(program_pulse_n), .mode(mode), .ext_exec(ext_exec),
		.cpu_reset(cpu_reset));
	ebsme_mem_model ebsme_mem_model_inst (.clk(clk), .fetch_pin(fsn), .latch_pin(lpin),
		.addr_lo(addr_lo), .p2_o(p2_o), .rd_n(rd_n), .host_fetch_low(host_fetch_low),
		.host_latch_drive(host_latch_drive), .host_latch_level(host_latch_level),
		.fetch_w(fetch_w), .latch_w(latch_w), .rd_addr(rd_addr));
	initial forever #10 clk = ~clk;
	// edge counters on the resolved pins; a hang ends the run as a mismatch
	always @(posedge clk) begin
		n_ale += (latch_w && !la_q);
		n_fs += (!fetch_w && fs_q);
		n_rd += (!rd_n && rd_q);
		n_wr += (!wr_n && wr_q);
		{la_q, fs_q, rd_q, wr_q} <= {latch_w, fetch_w, rd_n, wr_n};
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	task automatic chk(string what, logic [31:0] got, logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// settle 24 clocks (two machine cycles at standard speed, four at double), then clear counters; windows of 120 clocks hold whole cycles
	task automatic zero;
		repeat (24) @(negedge clk);
		{n_ale, n_fs, n_rd, n_wr} = '0;
	endtask
	task automatic win;
		zero();
		repeat (120) @(negedge clk);
	endtask
	task automatic t_rate;
		win();
		chk("ale std", n_ale, 20);
		chk("fetch idle", n_fs, 0);
		@(posedge clk) dbl <= 1;
		win();
		chk("ale dbl", n_ale, 40);
		@(posedge clk) dbl <= 0;
	endtask
	task automatic t_off;
		@(posedge clk) lpo <= 1;
		win();
		chk("ale off", n_ale, 0);
		@(posedge clk) lpo <= 0;
	endtask
	task automatic t_aux;
		@(posedge clk) {aux_wr, aux_wdata} <= 5'h15;
		@(posedge clk) aux_wr <= 0;
		repeat (6) @(negedge clk);
		chk("aux oe", ax_oe, 4'ha);
		chk("aux rd", aux_rdata, 4'h5);
		chk("aux o", ax_o, 4'h0);
		chk("p2 idle", p2_oe, 8'h00);
	endtask
	task automatic t_ext;
		@(posedge clk) efs_n <= 0;
		win();
		chk("fetch ext", n_fs, 20);
		chk("ext exec", ext_exec, 1);
		@(posedge clk) lock4 <= 1;
		win();
		chk("fetch lock", n_fs, 0);
		chk("lock exec", ext_exec, 0);
		@(posedge clk) lock4 <= 0;
	endtask
	// one wide access inside a ten-cycle window; request held until acknowledged
	task automatic t_data(input logic wr);
		zero();
		fork
			repeat (120) @(negedge clk);
			begin
				@(posedge clk) data_req <= '{1'b1, wr, 1'b1, 16'h12a5};
				for (int i = 0; i < 40 && data_ack !== 1'b1; i++) @(negedge clk);
				chk("ack", data_ack, 1);
				@(posedge clk) data_req.valid <= 0;
			end
		join
		chk("ale skip", n_ale, 19);
		chk("fetch skip", n_fs, 19);
		chk("rd", n_rd, !wr);
		chk("wr", n_wr, wr);
		chk("p2 drive", p2_oe, 8'hff);
		if (!wr) chk("addr", rd_addr, 16'h12a5);
	endtask
	task automatic t_rst;
		@(posedge clk) reset_pin <= 1;
		repeat (10) @(posedge clk) reset_pin <= 0;
		repeat (40) @(negedge clk);
		chk("short rst", cpu_reset, 0);
		@(posedge clk) reset_pin <= 1;
		repeat (60) @(negedge clk);
		chk("core rst", cpu_reset, 1);
		chk("rst mode", mode, EBSME_IN_RESET);
		repeat (300) @(posedge clk);
		host_fetch_low <= 1;
		repeat (10) @(posedge clk);
		reset_pin <= 0;
		repeat (10) @(negedge clk);
		chk("host", mode, EBSME_HOST);
		chk("ale oe", lpin.oe, 0);
		@(posedge clk) {host_latch_drive, host_latch_level} <= 2'b10;
		repeat (6) @(negedge clk);
		chk("program_pulse_n lo", program_pulse_n, 0);
		@(posedge clk) host_latch_level <= 1;
		repeat (6) @(negedge clk);
		chk("program_pulse_n hi", program_pulse_n, 1);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		reset <= 0;
		repeat (10) @(negedge clk);
		chk("boot", mode, EBSME_NORMAL);
		chk("core run", cpu_reset, 0);
		t_rate();
		t_off();
		t_aux();
		t_ext();
		t_data(0);
		t_data(1);
		t_rst();
		tally_and_finish();
	end
endmodule
